/* rtl/frr_delay_timer.sv */
`timescale 1ns/100ps
`include "frr_regs.svh"

module frr_delay_timer
  import frr_pkg::*;
#(
  parameter int WIDTH = 19
) (
  // Clock and control
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             clkEn,
  // Timer request
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] span,
  // Timer answer
  output logic                  done
);

  logic [WIDTH-1:0] cnt_ff;     // Cycles left
  logic [WIDTH-1:0] nxt_cnt;
  logic             done_ff;    // Expiry pulse
  logic             nxt_done;

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  // A zero span still takes one cycle so the strobe is never lost
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (load) begin
      nxt_cnt = (span == `FRR_TMR_ZERO) ? `FRR_TMR_ONE : span;
    end else if (cnt_ff != `FRR_TMR_ZERO) begin
      nxt_cnt  = cnt_ff - `FRR_TMR_ONE;
      nxt_done = (cnt_ff == `FRR_TMR_ONE);
    end
  end

  // Register stage, frozen while the clock enable is low
  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_ff  <= `FRR_TMR_ZERO;
      done_ff <= 1'b0;
    end else if (clkEn) begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

/* rtl/frr_fault_response.sv */
`timescale 1ns/100ps
`include "frr_regs.svh"

module frr_fault_response
  import frr_pkg::*;
#(
  parameter int UNIT_W = 16    // Width of the per-fault delay unit
) (
  // Clock and control
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clkEn,
  // Fault response configuration
  input  wire logic [1:0]        respMode,
  input  wire logic [2:0]        retryCode,
  input  wire logic [2:0]        delayCode,
  input  wire logic [UNIT_W-1:0] delayUnit,
  // Fault and clear events
  input  wire logic              faultEvt,
  input  wire frr_clear_t        clrSrc,
  input  wire logic              onRequest,
  // Power stage and status
  output logic                   outEnable,
  output logic                   faultLatched,
  output logic                   restartPulse,
  output logic [1:0]             retryCount
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  frr_regs_t   r_ff;            // All state
  frr_regs_t   nxt_r;           // Next state
  logic        timerDone;       // Restart delay elapsed
  logic        onOffOn;         // On request rose after being off
  logic        clrAny;          // Any clear source this cycle
  logic [18:0] spanCalc;        // Delay code times delay unit

  // Number of restarts the retry code allows; codes above the cap are
  // held to the cap since only one to three are defined here
  function automatic logic [1:0] retryLimit(input logic [2:0] code);
    logic [2:0] c;
    c = (code > `FRR_RETRY_CAP) ? `FRR_RETRY_CAP : code;
    return c[1:0];
  endfunction

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  assign onOffOn  = onRequest && !r_ff.prevOn;
  assign clrAny   = clrSrc.statusClr || clrSrc.clearAll || clrSrc.resetIn ||
                    clrSrc.biasLost || onOffOn;
  assign spanCalc = 19'(delayCode) * 19'(delayUnit);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // A fault in the cycle of a clear wins: it opens a new fault event
  always_comb begin
    nxt_r           = r_ff;
    nxt_r.restart   = 1'b0;
    nxt_r.timerLoad = 1'b0;
    nxt_r.prevOn    = onRequest;
    if (clrAny) begin
      // Clear drops the latch and restores the full retry budget
      nxt_r.st       = FRR_RUN;
      nxt_r.latched  = 1'b0;
      nxt_r.retryCnt = `FRR_CNT_ZERO;
    end
    unique case (nxt_r.st)
      FRR_RUN: begin
        nxt_r.outEn = onRequest;
      end
      FRR_WAIT: begin
        // Output stays off until the spacing timer expires
        nxt_r.outEn = 1'b0;
        // An expiry left over from an earlier load is ignored while a new
        // load is pending, and a fault in the expiry cycle gets no restart
        // so the attempt count only moves with a real start
        if (timerDone && !r_ff.timerLoad && !clrAny && !faultEvt) begin
          nxt_r.st       = FRR_RUN;
          nxt_r.restart  = 1'b1;
          nxt_r.outEn    = 1'b1;
          nxt_r.retryCnt = r_ff.retryCnt + `FRR_CNT_STEP;
        end
      end
      FRR_LATCHED: begin
        nxt_r.outEn = 1'b0;
      end
      default: begin
        nxt_r.st    = FRR_LATCHED;
        nxt_r.outEn = 1'b0;
      end
    endcase
    if (faultEvt) begin
      nxt_r.outEn   = 1'b0;
      nxt_r.restart = 1'b0;
      if (respMode == `FRR_MODE_LATCH) begin
        nxt_r.st      = FRR_LATCHED;
        nxt_r.latched = 1'b1;
      end else if (retryCode == `FRR_RETRY_NONE) begin
        nxt_r.st      = FRR_LATCHED;
        nxt_r.latched = 1'b1;
      end else if (nxt_r.retryCnt >= retryLimit(retryCode)) begin
        nxt_r.st      = FRR_LATCHED;
        nxt_r.latched = 1'b1;
      end else begin
        // Spacing is counted from this fault to the next start
        nxt_r.st        = FRR_WAIT;
        nxt_r.timerLoad = 1'b1;
        nxt_r.period    = spanCalc;
      end
    end
  end

  // Register stage, frozen while the clock enable is low
  always_ff @(posedge mclk) begin
    if (reset) begin
      r_ff.st        <= FRR_RUN;
      r_ff.retryCnt  <= `FRR_CNT_ZERO;
      r_ff.outEn     <= 1'b0;
      r_ff.latched   <= 1'b0;
      r_ff.restart   <= 1'b0;
      r_ff.prevOn    <= 1'b0;
      r_ff.timerLoad <= 1'b0;
      r_ff.period    <= `FRR_TMR_ZERO;
    end else if (clkEn) begin
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Restart spacing timer
  // ----------------------------------------------------------------
  frr_delay_timer #(
    .WIDTH (19)
  ) i_frr_delay_timer (
    .mclk  (mclk),
    .reset (reset),
    .clkEn (clkEn),
    .load  (r_ff.timerLoad),
    .span  (r_ff.period),
    .done  (timerDone)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign outEnable    = r_ff.outEn;
  assign faultLatched = r_ff.latched;
  assign restartPulse = r_ff.restart;
  assign retryCount   = r_ff.retryCnt;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [19:0] spanObs_ff;      // Enabled cycles since the timer load

  // Helper counter, only read by the spacing check
  always_ff @(posedge mclk) begin
    if (reset) begin
      spanObs_ff <= 20'h00000;
    end else if (clkEn) begin
      spanObs_ff <= r_ff.timerLoad ? 20'h00001 : spanObs_ff + 20'h00001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset || !clkEn);

  a_latch_off_out: assert property (
    (faultEvt && respMode == `FRR_MODE_LATCH) |=>
      (!outEnable && faultLatched && !restartPulse))
    else $error("latch-off fault left output on");

  a_latched_stays: assert property (
    (r_ff.st == FRR_LATCHED && !clrAny) |=> (!outEnable && faultLatched))
    else $error("latched fault released without clear");

  a_clear_unlatch: assert property (
    (r_ff.st == FRR_LATCHED && clrAny && !faultEvt) |=>
      (!faultLatched && retryCount == `FRR_CNT_ZERO))
    else $error("clear did not release latched fault");

  a_zero_retry: assert property (
    (faultEvt && retryCode == `FRR_RETRY_NONE) |=> faultLatched ##1 !restartPulse)
    else $error("restart attempted with retry code zero");

  a_retry_exhaust: assert property (
    (faultEvt && !clrAny && respMode != `FRR_MODE_LATCH &&
     retryCount >= retryLimit(retryCode)) |=> faultLatched)
    else $error("fault after last retry not latched");

  a_restart_space: assert property (
    $rose(restartPulse) |->
      (spanObs_ff == ((r_ff.period == `FRR_TMR_ZERO) ? 20'h00003 :
                      20'(r_ff.period) + 20'h00002)))
    else $error("restart spacing differs from delay setting");

  a_count_step: assert property (
    restartPulse |-> (retryCount == $past(retryCount) + `FRR_CNT_STEP))
    else $error("restart did not advance attempt count");

  c_latch_off:   cover property (faultEvt && respMode == `FRR_MODE_LATCH ##1 faultLatched);
  c_full_retry:  cover property (restartPulse && retryCount == 2'h3);
  c_onoff_clear: cover property (faultLatched && onOffOn ##1 !faultLatched);
  c_one_restart: cover property (faultEvt ##[1:300] restartPulse);

endmodule

/* rtl/frr_pkg.sv */
package frr_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FRR_RUN     = 2'b00,   // Output follows the on request
    FRR_WAIT    = 2'b01,   // Waiting out the restart delay
    FRR_LATCHED = 2'b10    // Held off until a clear
  } frr_state_t;

  // ----------------------------------------------------------------
  // Clear sources, gathered into one carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic statusClr;       // Individual status bit cleared
    logic clearAll;        // Clear-all-faults command
    logic resetIn;         // Reset signal input asserted
    logic biasLost;        // Bias power removed
  } frr_clear_t;

  // ----------------------------------------------------------------
  // Whole state of the main module
  // ----------------------------------------------------------------
  typedef struct packed {
    frr_state_t  st;        // Sequencer state
    logic [1:0]  retryCnt;  // Attempts made for this fault event
    logic        outEn;     // Output enable to the power stage
    logic        latched;   // Fault latched off
    logic        restart;   // One-cycle restart strobe
    logic        prevOn;    // On request seen last cycle
    logic        timerLoad; // One-cycle load strobe for the timer
    logic [18:0] period;    // Captured restart spacing in cycles
  } frr_regs_t;

endpackage

/* rtl/frr_regs.svh */
// Functional notes
// - Latch-off mode disables output until cleared
// - Clear by bit, command, reset, off-on, bias
// - Retry code zero means no restart attempt
// - Codes one to three allow that many restarts
// - Restart starts spaced by delay code times unit
`ifndef FRR_REGS_SVH
`define FRR_REGS_SVH

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define FRR_MODE_LATCH  2'h3    // Response field code for latch-off
`define FRR_RETRY_NONE  3'h0    // Retry field code for no restart
`define FRR_RETRY_CAP   3'h3    // Highest retry code with a defined count

// ----------------------------------------------------------------
// Counter constants
// ----------------------------------------------------------------
`define FRR_CNT_ZERO    2'h0    // Attempt count after clear or reset
`define FRR_CNT_STEP    2'h1    // Attempt count increment
`define FRR_TMR_ONE     19'h00001 // Shortest timer span and last tick value
`define FRR_TMR_ZERO    19'h00000 // Idle timer value

`endif

/* sim/fault_response_retry_tb_top.sv */
`timescale 1ns/100ps

module fault_response_retry_tb_top;
  import frr_pkg::*;

  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  logic       mclk = 1'h0;
  logic       reset = 1'h1;
  logic       clkEn = 1'h1;
  logic       faultEvt = 1'h0;
  logic [1:0] respMode;
  logic [2:0] retryCode;
  logic [2:0] delayCode;
  logic [15:0] delayUnit;
  frr_clear_t clrSrc;
  logic       onRequest;
  logic       outEnable;
  logic       faultLatched;
  logic       restartPulse;
  logic [1:0] retryCount;
  int         miscompares = 0;
  int         checksDone = 0;

  always #25 mclk = ~mclk;

  frr_host_model i_frr_host_model (.mclk(mclk), .respMode(respMode), .retryCode(retryCode),
    .delayCode(delayCode), .delayUnit(delayUnit), .clrSrc(clrSrc), .onRequest(onRequest));

  frr_fault_response i_frr_fault_response (.mclk(mclk), .reset(reset), .clkEn(clkEn),
    .respMode(respMode), .retryCode(retryCode), .delayCode(delayCode),
    .delayUnit(delayUnit), .faultEvt(faultEvt), .clrSrc(clrSrc), .onRequest(onRequest),
    .outEnable(outEnable), .faultLatched(faultLatched), .restartPulse(restartPulse),
    .retryCount(retryCount));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle fault; returns just after the edge that takes it
  task automatic fault();
    @(posedge mclk);
    faultEvt <= 1'h1;
    @(posedge mclk);
    faultEvt <= 1'h0;
    #1;
  endtask

  // Edges from the fault edge to the restart strobe, bounded
  task automatic wait_restart(output int n);
    n = 0;
    #1;
    while (restartPulse !== 1'h1 && n < 200) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      give_verdict();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Latch-off: held off, then each clear source in turn releases it
  task automatic latch_test();
    i_frr_host_model.configure(2'h3, 3'h1, 3'h0, 16'h0001);
    fault();
    repeat (20) @(posedge mclk);
    #1;
    chk("outEnable", 8'h00, 8'(outEnable));
    chk("faultLatched", 8'h01, 8'(faultLatched));
    for (int idx = 0; idx < 4; idx++) begin
      i_frr_host_model.clear_one(idx);
      #1;
      chk("faultLatched", 8'h00, 8'(faultLatched));
      fault();
    end
    i_frr_host_model.off_on();
    @(posedge mclk);
    #1;
    chk("faultLatched", 8'h00, 8'(faultLatched));
    chk("outEnable", 8'h01, 8'(outEnable));
  endtask

  // Retry code zero: no restart strobe at all, output stays off
  task automatic no_retry_test();
    int pulses;
    pulses = 0;
    i_frr_host_model.configure(2'h0, 3'h0, 3'h1, 16'h0001);
    fault();
    repeat (30) begin
      @(posedge mclk);
      #1;
      pulses += int'(restartPulse === 1'h1);
    end
    chk("restarts", 8'h00, 8'(pulses));
    chk("outEnable", 8'h00, 8'(outEnable));
    i_frr_host_model.clear_one(0);
  endtask

  // Codes one to three: spacing, count, final latch, fresh count after clear
  task automatic retry_test();
    int n;
    for (int c = 1; c < 4; c++) begin
      i_frr_host_model.configure(2'h0, 3'(c), 3'h2, 16'h0003);
      for (int i = 0; i < c; i++) begin
        fault();
        wait_restart(n);
        chk("spacing", 8'h08, 8'(n));
        chk("retryCount", 8'(i + 1), 8'(retryCount));
        chk("outEnable", 8'h01, 8'(outEnable));
      end
      fault();
      chk("faultLatched", 8'h01, 8'(faultLatched));
      chk("outEnable", 8'h00, 8'(outEnable));
      i_frr_host_model.clear_one(2);
      #1;
      chk("retryCount", 8'h00, 8'(retryCount));
      fault();
      wait_restart(n);
      chk("retryCount", 8'h01, 8'(retryCount));
      i_frr_host_model.clear_one(1);
    end
  endtask

  // Clock enable low in mid-wait: the delay counts enabled cycles only,
  // one enabled edge passes before the freeze, so five remain of six
  task automatic freeze_test();
    int n;
    i_frr_host_model.configure(2'h0, 3'h1, 3'h1, 16'h0004);
    fault();
    @(posedge mclk);
    clkEn <= 1'h0;
    repeat (5) @(posedge mclk);
    clkEn <= 1'h1;
    #1;
    chk("retryCount", 8'h00, 8'(retryCount));
    chk("outEnable", 8'h00, 8'(outEnable));
    wait_restart(n);
    chk("spacing", 8'h05, 8'(n));
    chk("retryCount", 8'h01, 8'(retryCount));
    i_frr_host_model.clear_one(3);
  endtask

  // Codes above three act as three; a zero delay still takes one cycle
  task automatic cap_test();
    int n;
    i_frr_host_model.configure(2'h2, 3'h7, 3'h0, 16'h0009);
    for (int i = 0; i < 3; i++) begin
      fault();
      wait_restart(n);
      chk("spacing", 8'h03, 8'(n));
      chk("retryCount", 8'(i + 1), 8'(retryCount));
    end
    fault();
    chk("faultLatched", 8'h01, 8'(faultLatched));
    chk("outEnable", 8'h00, 8'(outEnable));
    i_frr_host_model.clear_one(0);
    #1;
    chk("retryCount", 8'h00, 8'(retryCount));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    repeat (3) @(posedge mclk);
    latch_test();
    no_retry_test();
    retry_test();
    freeze_test();
    cap_test();
    give_verdict();
  end
endmodule

/* sim/frr_host_model.sv */
`timescale 1ns/100ps

module frr_host_model
  import frr_pkg::*;
(
  // Clock
  input  wire logic  mclk,
  // Configuration fields
  output logic [1:0]  respMode,
  output logic [2:0]  retryCode,
  output logic [2:0]  delayCode,
  output logic [15:0] delayUnit,
  // Clear sources and on request
  output frr_clear_t  clrSrc,
  output logic        onRequest
);
  // ----------------------------------------------------------------
  // Host side levels
  // ----------------------------------------------------------------
  // Known values from time zero, so nothing floats before reset
  initial begin
    respMode  = 2'h0;
    retryCode = 3'h0;
    delayCode = 3'h0;
    delayUnit = 16'h0001;
    clrSrc    = '0;
    onRequest = 1'h1;
  end

  // Program all fields in one write, just after an edge
  task automatic configure(input logic [1:0] m, input logic [2:0] r,
                           input logic [2:0] d, input logic [15:0] u);
    @(posedge mclk);
    respMode  <= m;
    retryCode <= r;
    delayCode <= d;
    delayUnit <= u;
  endtask

  // Single clear source held for exactly one edge
  task automatic clear_one(input int idx);
    @(posedge mclk);
    clrSrc[idx] <= 1'h1;
    @(posedge mclk);
    clrSrc <= '0;
  endtask

  // Turn off, then back on; the rising request is the clear
  task automatic off_on();
    @(posedge mclk);
    onRequest <= 1'h0;
    @(posedge mclk);
    onRequest <= 1'h1;
  endtask
endmodule
